/* File: rtl/dp_static_cfg.sv */
// Purpose: configuration layer and 8-bit datapath slice with APB register access
// Assumes: state and routing inputs are logic on pclk; chain ports face neighbour slices
// Notes:   chain outputs are combinational so chained slices settle in one cycle
//
// What this block does
// - eight dynamic words, current state's word applies
// - static fields act identically in every state
// - optional 8-bit AND mask on shifter output
// - optional masks on accumulators before comparing
// - dynamic bit picks compare option A/B
// - carry-in arithmetic or registered previous carry
// - carry-in routed or chained from previous slice
// - default shift-in is constant zero or one
// - bus mode: CPU writes FIFO, datapath consumes
// - FIFO loads from acc0, acc1, ALU; CPU reads
// - chosen MSB moves shift-in, shift-out, carry-out
// - CRC top bit may come from next slice
// - CRC feedback may come from previous slice
// - condition sets may combine with previous slice
// - chain directions: up for carries, down for right
`timescale 1ns/10ps
`include "dp_cfg_consts.svh"
module dp_static_cfg
  import dp_cfg_pkg::*;
#(
  parameter bit IS_LSB_SLICE = 1'b0,
  parameter bit IS_MSB_SLICE = 1'b0
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  state_in,
  input  wire logic        route_carry_in,
  input  wire logic        route_shift_in,
  input  wire logic        fifo_zero_load,
  input  wire logic        fifo_one_load,
  input  wire logic        carry_chain_in,
  input  wire logic        shift_left_chain_in,
  input  wire logic        shift_right_chain_in,
  input  wire logic [3:0]  cond_zero_chain_in,
  input  wire logic [3:0]  cond_one_chain_in,
  input  wire logic        crc_fb_chain_in,
  input  wire logic        crc_msb_chain_in,
  output logic             carry_out,
  output logic             shift_left_out,
  output logic             shift_right_out,
  output logic      [3:0]  cond_zero_out,
  output logic      [3:0]  cond_one_out,
  output logic             crc_fb_out,
  output logic             crc_msb_out
);

  dp_state_s s_reg;
  dp_state_s s_next;

  logic [15:0]     dyn;
  logic [15:0]     chain_eff;
  alu_func_e       func;
  srcb_e           srcb;
  shift_e          shift_op;
  in_src_e         ci_src;
  in_src_e         si_src;
  cmp_opt_e        cmp_opt;
  logic [2:0]      msb;
  logic [7:0]      lane;
  logic [7:0]      opa;
  logic [7:0]      opb;
  logic [7:0]      opb_x;
  logic            is_alu_arithmetic_carry;
  logic            alu_arithmetic_carry_ci;
  logic            cin;
  logic            sin;
  logic [8:0]      sum_full;
  logic [8:0]      sum_lane;
  logic [7:0]      logic_res;
  logic [7:0]      alu_res;
  logic [7:0]      shifted;
  logic            crc_top;
  logic            crc_fb;
  logic [7:0]      crc_res;
  logic [7:0]      dp_out;
  logic [7:0]      cmp_acc_zero;
  logic [7:0]      cmp_acc_one;
  logic [1:0][7:0] cmp_lhs;
  logic [1:0][7:0] cmp_rhs;
  logic [1:0][3:0] cond_in;
  logic [1:0][3:0] cond_out;
  logic [1:0]      cond_chain;
  logic            setup;
  logic            wr_acc;
  logic            rd_acc;
  reg_id_e         rd_id;
  reg_id_e         wr_id;

  // one decoder for the setup-phase read and the access-phase write
  function automatic reg_id_e decode(input logic [7:0] addr);
    reg_id_e id;
    id = RG_NONE;
    if (addr[1:0] != 2'b00)
      id = RG_NONE;
    else if (addr <= `OFS_RAM_LAST)
      id = RG_RAM;
    else if (addr == `OFS_ALU_MASK)
      id = RG_ALUMASK;
    else if (addr == `OFS_CMP_MASK)
      id = RG_CMPMASK;
    else if (addr == `OFS_SEL)
      id = RG_SEL;
    else if (addr == `OFS_CHAIN)
      id = RG_CHAIN;
    else if (addr == `OFS_FIFO_ZERO)
      id = RG_FIFO0;
    else if (addr == `OFS_FIFO_ONE)
      id = RG_FIFO1;
    else if (addr == `OFS_DATA)
      id = RG_DATA;
    else if (addr == `OFS_ACC)
      id = RG_ACC;
    else if (addr == `OFS_STATUS)
      id = RG_STATUS;
    return id;
  endfunction

  // the current state picks the dynamic word; static regs are not indexed by state
  assign dyn      = s_reg.ram[state_in];
  assign func     = alu_func_e'(dyn[`DYN_FUNC_HI:`DYN_FUNC_LO]);
  assign srcb     = srcb_e'(dyn[`DYN_SRCB_HI:`DYN_SRCB_LO]);
  assign shift_op = shift_e'(dyn[`DYN_SHIFT_HI:`DYN_SHIFT_LO]);

  // end slices ignore the condition and crc chain inputs that have no neighbour behind them
  assign chain_eff = s_reg.chain
                   & ~(IS_LSB_SLICE ? 16'h0013 : 16'h0000)
                   & ~(IS_MSB_SLICE ? 16'h0020 : 16'h0000);

  // per-cycle choice between option A and option B of each static select
  assign ci_src  = in_src_e'(dyn[`DYN_CI_SEL] ? s_reg.sel[`SEL_CIB_LO +: 2]
                                              : s_reg.sel[`SEL_CIA_LO +: 2]);
  assign si_src  = in_src_e'(dyn[`DYN_SI_SEL] ? s_reg.sel[`SEL_SIB_LO +: 2]
                                              : s_reg.sel[`SEL_SIA_LO +: 2]);
  assign cmp_opt = cmp_opt_e'(dyn[`DYN_COMPARE_CONFIG_SELECT] ? s_reg.sel[`SEL_CMPB_LO +: 2]
                                                : s_reg.sel[`SEL_CMPA_LO +: 2]);

  // selected MSB; lane covers bits msb..0
  assign msb  = s_reg.chain[`CH_MSB_EN] ? s_reg.chain[`CH_MSB_SEL_LO +: 3] : 3'd7;
  assign lane = 8'hFF >> (3'd7 - msb);

  // operand selection and arithmetic carry of each function
  assign opa      = dyn[`DYN_SRCA] ? s_reg.acc[1] : s_reg.acc[0];
  assign opb      = (srcb == SB_D0) ? s_reg.data[0] :
                    (srcb == SB_DATA1) ? s_reg.data[1] :
                    (srcb == SB_ACC0)  ? s_reg.acc[0]  : s_reg.acc[1];
  assign opb_x    = (func == FN_SUB) ? ~opb :
                    (func == FN_DEC) ? 8'hFF :
                    (func == FN_INC) ? 8'h00 : opb;
  assign is_alu_arithmetic_carry = (func == FN_INC) | (func == FN_DEC) | (func == FN_ADD) | (func == FN_SUB);
  assign alu_arithmetic_carry_ci = (func == FN_INC) | (func == FN_SUB);

  // carry-in source; a chained carry arrives from the less significant slice
  always_comb
  begin
    case (ci_src)
      SRC_DEFAULT:    cin = alu_arithmetic_carry_ci;
      SRC_REGISTERED: cin = s_reg.carry;
      SRC_ROUTED:     cin = route_carry_in;
      default:        cin = IS_LSB_SLICE ? alu_arithmetic_carry_ci : carry_chain_in;
    endcase
  end

  // shift-in source; chained input depends on shift direction
  always_comb
  begin
    case (si_src)
      SRC_DEFAULT:    sin = s_reg.sel[`SEL_SI_VALUE];
      SRC_REGISTERED: sin = s_reg.sor;
      SRC_ROUTED:     sin = route_shift_in;
      default:        sin = (shift_op == SH_RIGHT) ? shift_right_chain_in
                                                   : shift_left_chain_in;
    endcase
  end

  // full sum for the result, lane sum for the carry at the chosen msb
  assign sum_full = {1'b0, opa} + {1'b0, opb_x} + {8'h00, cin};
  assign sum_lane = {1'b0, opa & lane} + {1'b0, opb_x & lane} + {8'h00, cin};
  assign logic_res = (func == FN_XOR) ? (opa ^ opb) :
                     (func == FN_AND) ? (opa & opb) :
                     (func == FN_OR)  ? (opa | opb) : opa;
  assign alu_res   = is_alu_arithmetic_carry ? sum_full[7:0] : logic_res;

  // right shift inserts at the chosen msb, left shift at bit 0
  always_comb
  begin
    case (shift_op)
      SH_LEFT:  shifted = {alu_res[6:0], sin};
      SH_RIGHT: shifted = (alu_res >> 1) & ~(8'h01 << msb) | ({7'h00, sin} << msb);
      SH_SWAP:  shifted = {alu_res[3:0], alu_res[7:4]};
      default:  shifted = alu_res;
    endcase
  end

  // crc: top bit travels down, feedback travels up the chain
  assign crc_top = chain_eff[`CH_CMSB] ? crc_msb_chain_in : opa[msb];
  assign crc_fb  = chain_eff[`CH_FB] ? crc_fb_chain_in : (crc_top ^ sin);
  assign crc_res = (dyn[`DYN_CFB_EN] & crc_fb) ? (shifted ^ opb) : shifted;

  // output mask gates the shifter result only when enabled
  assign dp_out = crc_res & (s_reg.sel[`SEL_OUT_MASK_EN] ? s_reg.alu_mask : 8'hFF);

  // outgoing chain signals, combinational for single-cycle wide words
  assign carry_out       = is_alu_arithmetic_carry & sum_lane[{1'b0, msb} + 4'd1];
  assign shift_left_out  = alu_res[msb];
  assign shift_right_out = alu_res[0];
  assign crc_fb_out      = crc_fb;
  assign crc_msb_out     = opa[msb];

  // compare inputs masked per enable
  assign cmp_acc_zero = s_reg.acc[0]
                      & (s_reg.sel[`SEL_MASK0_EN] ? s_reg.cmp_mask[7:0] : 8'hFF);
  assign cmp_acc_one  = s_reg.acc[1]
                      & (s_reg.sel[`SEL_MASK1_EN] ? s_reg.cmp_mask[15:8] : 8'hFF);
  assign cmp_lhs[0] = cmp_acc_zero;
  assign cmp_rhs[0] = s_reg.data[0];
  assign cmp_lhs[1] = ((cmp_opt == CMP_ACC0_DATA1) | (cmp_opt == CMP_ACC0_ACC1)) ? cmp_acc_zero
                                                                         : cmp_acc_one;
  assign cmp_rhs[1] = (cmp_opt == CMP_ACC_ONE_VS_DATA_ONE) ? s_reg.data[1] :
                      (cmp_opt == CMP_ACC1_ACC0)  ? cmp_acc_zero  :
                      (cmp_opt == CMP_ACC0_DATA1) ? s_reg.data[1] : cmp_acc_one;
  assign cond_in[0]    = cond_zero_chain_in;
  assign cond_in[1]    = cond_one_chain_in;
  assign cond_chain    = {chain_eff[`CH_COND1], chain_eff[`CH_COND0]};
  assign cond_zero_out = cond_out[0];
  assign cond_one_out  = cond_out[1];

  // two condition sets, each chainable from the previous slice
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_cond
      dp_condition_unit u_cond
      (
        .lhs      (cmp_lhs[g]),
        .rhs      (cmp_rhs[g]),
        .chain_en (cond_chain[g]),
        .cond_in  (cond_in[g]),
        .cond_out (cond_out[g])
      );
    end
  endgenerate

  // apb: zero wait states, read data prepared during setup
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign rd_id   = decode(paddr);
  assign wr_id   = decode(paddr);
  assign pready  = 1'b1;
  assign prdata  = s_reg.rdata;
  assign pslverr = s_reg.err & psel & penable;

  // next state: bus access, fifo traffic, accumulator writes, registered carry
  always_comb
  begin
    fifo_in_e fsel;
    acc_wr_e  wsrc;
    logic     pop;
    logic     load;
    logic [7:0] lval;
    s_next = s_reg;
    fsel   = FI_BUS;
    wsrc   = WR_NONE;
    pop    = 1'b0;
    load   = 1'b0;
    lval   = 8'h00;
    s_next.carry = carry_out;
    s_next.sor   = shift_right_out;
    if (setup)
    begin
      s_next.err = (rd_id == RG_NONE);
      case (rd_id)
        RG_RAM:    s_next.rdata = {16'h0000, s_reg.ram[paddr[4:2]]};
        RG_ALUMASK: s_next.rdata = {24'h00_0000, s_reg.alu_mask};
        RG_CMPMASK: s_next.rdata = {16'h0000, s_reg.cmp_mask};
        RG_SEL:    s_next.rdata = {16'h0000, s_reg.sel};
        RG_CHAIN:  s_next.rdata = {16'h0000, s_reg.chain};
        RG_FIFO0:  s_next.rdata = {23'h00_0000, s_reg.fifo_full[0], s_reg.fifo[0]};
        RG_FIFO1:  s_next.rdata = {23'h00_0000, s_reg.fifo_full[1], s_reg.fifo[1]};
        RG_DATA:   s_next.rdata = {16'h0000, s_reg.data};
        RG_ACC:    s_next.rdata = {16'h0000, s_reg.acc};
        RG_STATUS: s_next.rdata = {24'h00_0000, s_reg.fifo_full, s_reg.carry, s_reg.sor,
                                   1'b0, state_in};
        default:   s_next.rdata = `RST_READ;
      endcase
    end
    if (wr_acc)
    begin
      case (wr_id)
        RG_RAM:   s_next.ram[paddr[4:2]] = pwdata[15:0];
        RG_ALUMASK: s_next.alu_mask = pwdata[7:0];
        RG_CMPMASK: s_next.cmp_mask = pwdata[15:0];
        RG_SEL:   s_next.sel = pwdata[15:0];
        RG_CHAIN: s_next.chain = pwdata[15:0];
        RG_DATA:  s_next.data = pwdata[15:0];
        default:  s_next.err = s_reg.err;
      endcase
    end
    for (int i = 0; i < 2; i++)
    begin
      fsel = fifo_in_e'(s_reg.chain[(i == 0 ? `CH_F0SEL_LO : `CH_F1SEL_LO) +: 2]);
      wsrc = acc_wr_e'(i == 0 ? dyn[`DYN_A0WR_HI:`DYN_A0WR_LO] : dyn[`DYN_A1WR_HI:`DYN_A1WR_LO]);
      // accumulator write source of the current state
      case (wsrc)
        WR_ALU:  s_next.acc[i] = dp_out;
        WR_DATA: s_next.acc[i] = s_reg.data[i];
        WR_FIFO: s_next.acc[i] = s_reg.fifo[i];
        default: s_next.acc[i] = s_reg.acc[i];
      endcase
      if (fsel == FI_BUS)
      begin
        // cpu fills, datapath drains; a full fifo refuses cpu writes unless the datapath pops it in the same cycle
        pop  = (wsrc == WR_FIFO) & s_reg.fifo_full[i];
        load = wr_acc & (wr_id == (i == 0 ? RG_FIFO0 : RG_FIFO1));
        lval = pwdata[7:0];
      end
      else
      begin
        // datapath fills from acc or alu, cpu read drains
        pop  = rd_acc & (rd_id == (i == 0 ? RG_FIFO0 : RG_FIFO1));
        load = (i == 0) ? fifo_zero_load : fifo_one_load;
        lval = (fsel == FI_ACC_ZERO) ? s_reg.acc[0] :
               (fsel == FI_ACC_ONE)  ? s_reg.acc[1] : dp_out;
      end
      // a load in the same cycle as a pop wins over the pop
      s_next.fifo_full[i] = s_reg.fifo_full[i] & ~pop;
      if (load & (~s_reg.fifo_full[i] | pop))
      begin
        s_next.fifo[i]      = lval;
        s_next.fifo_full[i] = 1'b1;
      end
    end
  end

  // single state register; every field resets to its default
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg           <= '0;
      s_reg.sel       <= `RST_WORD;
      s_reg.chain     <= `RST_WORD;
      s_reg.alu_mask  <= `RST_BYTE;
      s_reg.rdata     <= `RST_READ;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

/* File: rtl/dp_cfg_consts.svh */
// Purpose: offsets, field positions, reset values of the datapath configuration layer
// Assumes: 32-bit APB data, one aligned word per register, byte addresses below
// Notes:   definitions only
`ifndef DP_CFG_CONSTS_SVH
`define DP_CFG_CONSTS_SVH

// register byte addresses
`define OFS_RAM_LAST      8'h1C
`define OFS_ALU_MASK      8'h20
`define OFS_CMP_MASK      8'h24
`define OFS_SEL           8'h28
`define OFS_CHAIN         8'h2C
`define OFS_FIFO_ZERO     8'h30
`define OFS_FIFO_ONE      8'h34
`define OFS_DATA          8'h38
`define OFS_ACC           8'h3C
`define OFS_STATUS        8'h40

// reset values
`define RST_WORD          16'h0000
`define RST_BYTE          8'h00
`define RST_READ          32'h0000_0000

// dynamic word fields
`define DYN_FUNC_HI       15
`define DYN_FUNC_LO       13
`define DYN_SRCA          12
`define DYN_SRCB_HI       11
`define DYN_SRCB_LO       10
`define DYN_SHIFT_HI      9
`define DYN_SHIFT_LO      8
`define DYN_A0WR_HI       7
`define DYN_A0WR_LO       6
`define DYN_A1WR_HI       5
`define DYN_A1WR_LO       4
`define DYN_CFB_EN        3
`define DYN_CI_SEL        2
`define DYN_SI_SEL        1
`define DYN_COMPARE_CONFIG_SELECT       0

// compare_carry_shift_select fields
`define SEL_CMPB_LO       14
`define SEL_CMPA_LO       12
`define SEL_CIB_LO        10
`define SEL_CIA_LO        8
`define SEL_MASK1_EN      7
`define SEL_MASK0_EN      6
`define SEL_OUT_MASK_EN   5
`define SEL_SI_VALUE      4
`define SEL_SIB_LO        2
`define SEL_SIA_LO        0

// fifo_msb_chain_config fields
`define CH_F1SEL_LO       14
`define CH_F0SEL_LO       12
`define CH_MSB_EN         11
`define CH_MSB_SEL_LO     8
`define CH_CMSB           5
`define CH_FB             4
`define CH_COND1          1
`define CH_COND0          0

`endif

/* File: rtl/dp_cfg_pkg.sv */
// Purpose: types of the datapath configuration layer
// Assumes: field positions from dp_cfg_consts.svh
// Notes:   all module state is one packed struct
package dp_cfg_pkg;

  typedef enum logic [2:0] {
    FN_PASS = 3'b000, FN_INC = 3'b001, FN_DEC = 3'b010, FN_ADD = 3'b011,
    FN_SUB  = 3'b100, FN_XOR = 3'b101, FN_AND = 3'b110, FN_OR  = 3'b111
  } alu_func_e;

  typedef enum logic [1:0] {
    SB_D0 = 2'b00, SB_DATA1 = 2'b01, SB_ACC0 = 2'b10, SB_ACC1 = 2'b11
  } srcb_e;

  typedef enum logic [1:0] {
    SH_PASS = 2'b00, SH_LEFT = 2'b01, SH_RIGHT = 2'b10, SH_SWAP = 2'b11
  } shift_e;

  typedef enum logic [1:0] {
    WR_NONE = 2'b00, WR_ALU = 2'b01, WR_DATA = 2'b10, WR_FIFO = 2'b11
  } acc_wr_e;

  // compare set 1 operand pairs
  typedef enum logic [1:0] {
    CMP_ACC_ONE_VS_DATA_ONE = 2'b00, CMP_ACC1_ACC0 = 2'b01,
    CMP_ACC0_DATA1 = 2'b10, CMP_ACC0_ACC1 = 2'b11
  } cmp_opt_e;

  // carry-in and shift-in sources share one encoding
  typedef enum logic [1:0] {
    SRC_DEFAULT = 2'b00, SRC_REGISTERED = 2'b01, SRC_ROUTED = 2'b10, SRC_CHAINED = 2'b11
  } in_src_e;

  typedef enum logic [1:0] {
    FI_BUS = 2'b00, FI_ACC_ZERO = 2'b01, FI_ACC_ONE = 2'b10, FI_ALU = 2'b11
  } fifo_in_e;

  typedef enum logic [3:0] {
    RG_RAM = 4'h0, RG_ALUMASK = 4'h1, RG_CMPMASK = 4'h2, RG_SEL = 4'h3, RG_CHAIN = 4'h4,
    RG_FIFO0 = 4'h5, RG_FIFO1 = 4'h6, RG_DATA = 4'h7, RG_ACC = 4'h8, RG_STATUS = 4'h9,
    RG_NONE = 4'hF
  } reg_id_e;

  typedef struct packed {
    logic [7:0][15:0] ram;
    logic [7:0]       alu_mask;
    logic [15:0]      cmp_mask;
    logic [15:0]      sel;
    logic [15:0]      chain;
    logic [1:0][7:0]  data;
    logic [1:0][7:0]  acc;
    logic [1:0][7:0]  fifo;
    logic [1:0]       fifo_full;
    logic             carry;
    logic             sor;
    logic [31:0]      rdata;
    logic             err;
  } dp_state_s;

endpackage

/* File: rtl/dp_condition_unit.sv */
// Purpose: one condition set: less, equal, zero, all-ones, with optional chaining
// Assumes: chained inputs come from the less significant slice on the same clock
// Notes:   bit order of cond vectors is {less, equal, zero, all_ones}
`timescale 1ns/10ps
module dp_condition_unit
(
  input  wire logic [7:0] lhs,
  input  wire logic [7:0] rhs,
  input  wire logic       chain_en,
  input  wire logic [3:0] cond_in,
  output logic      [3:0] cond_out
);
  logic [3:0] local_cond;

  // local compare on already masked operands
  assign local_cond = {lhs < rhs, lhs == rhs, lhs == 8'h00, lhs == 8'hFF};

  // chained: lower slice decides less only when this byte is equal
  always_comb
  begin
    if (chain_en)
    begin
      cond_out[3] = local_cond[3] | (local_cond[2] & cond_in[3]);
      cond_out[2] = local_cond[2] & cond_in[2];
      cond_out[1] = local_cond[1] & cond_in[1];
      cond_out[0] = local_cond[0] & cond_in[0];
    end
    else
    begin
      cond_out = local_cond;
    end
  end
endmodule

/* File: testbench/dp_cfg_checker_assertions.sv */
// Purpose: port-level checks of the datapath configuration slice
// Assumes: zero-wait APB; chaining bits shadowed from bus writes
// Notes:   bound to every dp_static_cfg instance
`timescale 1ns/10ps
module dp_cfg_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  cond_zero_chain_in,
  input wire logic [3:0]  cond_one_chain_in,
  input wire logic [3:0]  cond_zero_out,
  input wire logic [3:0]  cond_one_out
);
  logic [1:0] chain_reg;
  logic       acc_cyc;

  // shadow of the two condition chaining bits, updated on the write edge
  assign acc_cyc = psel && penable;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chain_reg <= 2'b00;
    else if (acc_cyc && pwrite && pready && paddr == 8'h2C)
      chain_reg <= pwdata[1:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_always; pready; endproperty
  a_ready_always: assert property (p_ready_always) else $error("pready dropped");
  property p_err_in_access; pslverr |-> acc_cyc; endproperty
  a_err_in_access: assert property (p_err_in_access) else $error("pslverr outside access");
  property p_err_unaligned; acc_cyc && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned not refused");
  property p_err_unmapped; acc_cyc && paddr > 8'h40 |-> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_reset_clear; $rose(presetn) |-> prdata == 32'h0000_0000; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("read data not clear");
  // chained equal, zero and all-ones hold only when the lower slice agrees; chained less follows the lower slice when equal
  property p_eq0_chain; chain_reg[0] && !cond_zero_chain_in[2] |-> !cond_zero_out[2]; endproperty
  a_eq0_chain: assert property (p_eq0_chain) else $error("equal not chained");
  property p_less0_chain;
    chain_reg[0] && cond_zero_out[2] && cond_zero_chain_in[3] |-> cond_zero_out[3];
  endproperty
  a_less0_chain: assert property (p_less0_chain) else $error("less not chained");
  property p_zero1_chain; chain_reg[1] && !cond_one_chain_in[1] |-> !cond_one_out[1]; endproperty
  a_zero1_chain: assert property (p_zero1_chain) else $error("zero not chained");
  property p_ones1_chain; chain_reg[1] && !cond_one_chain_in[0] |-> !cond_one_out[0]; endproperty
  a_ones1_chain: assert property (p_ones1_chain) else $error("all-ones not chained");

  c_chain_write: cover property (acc_cyc && pwrite && paddr == 8'h2C);
  c_slverr: cover property (pslverr);
  c_cond_chained: cover property (chain_reg[0] && cond_zero_out[3]);
endmodule

bind dp_static_cfg dp_cfg_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .cond_zero_chain_in, .cond_one_chain_in,
  .cond_zero_out, .cond_one_out);

/* File: testbench/dp_neighbour_model.sv */
// Purpose: neighbouring slices and routing fabric around one slice
// Assumes: neighbours run on pclk and change just after its edge
// Notes:   a 5-bit counter sweeps its 32 values through the chained inputs while run is high
`timescale 1ns/10ps
module dp_neighbour_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  output logic            route_carry_in,
  output logic            route_shift_in,
  output logic            carry_chain_in,
  output logic            shift_left_chain_in,
  output logic            shift_right_chain_in,
  output logic      [3:0] cond_zero_chain_in,
  output logic      [3:0] cond_one_chain_in,
  output logic            crc_fb_chain_in,
  output logic            crc_msb_chain_in
);
  logic [4:0] cnt_reg;

  // sweep counter; holding it keeps neighbours quiet during bus tests
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 5'h00;
    else if (run)
      cnt_reg <= cnt_reg + 5'h01;
  end

  // lower slice sends conditions, carry, left shift and crc feedback
  assign cond_zero_chain_in   = cnt_reg[3:0];
  assign cond_one_chain_in    = ~cnt_reg[3:0];
  assign carry_chain_in       = cnt_reg[1];
  assign shift_left_chain_in  = cnt_reg[2];
  assign crc_fb_chain_in      = cnt_reg[0];
  // upper slice sends right shift and crc top bit downwards
  assign shift_right_chain_in = cnt_reg[3];
  assign crc_msb_chain_in     = cnt_reg[4];
  // routing fabric
  assign route_carry_in       = cnt_reg[4];
  assign route_shift_in       = cnt_reg[0] ^ cnt_reg[4];
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the datapath configuration slice
// Assumes: zero-wait APB slave, word-per-register map at byte offsets
// Notes:   register rows first, then datapath and reset cases
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run;
  logic        fifo_zero_load, fifo_one_load, carry_out, shift_left_out, shift_right_out;
  logic        route_carry_in, route_shift_in, carry_chain_in, shift_left_chain_in;
  logic        shift_right_chain_in, crc_fb_chain_in, crc_msb_chain_in, crc_fb_out, crc_msb_out;
  logic [3:0]  cond_zero_chain_in, cond_one_chain_in, cond_zero_out, cond_one_out;
  logic [2:0]  state_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, n_compared;
  row_s        rows [8] = '{'{8'h20, 32'hFFFF_FFA5, 32'h0000_00A5, 1'b0},
    '{8'h24, 32'h1234_C33C, 32'h0000_C33C, 1'b0}, '{8'h28, 32'hFFFF_5A5A, 32'h0000_5A5A, 1'b0},
    '{8'h2C, 32'h0000_FF33, 32'h0000_FF33, 1'b0}, '{8'h1C, 32'h0001_8421, 32'h0000_8421, 1'b0},
    '{8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0}, '{8'h21, 32'h0000_0001, 32'h0000_0000, 1'b1},
    '{8'h44, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  logic [15:0] words [4] = '{16'h0080, 16'h0040, 16'h0140, 16'h0030};

  dp_static_cfg i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .state_in, .route_carry_in, .route_shift_in, .fifo_zero_load,
    .fifo_one_load, .carry_chain_in, .shift_left_chain_in, .shift_right_chain_in,
    .cond_zero_chain_in, .cond_one_chain_in, .crc_fb_chain_in, .crc_msb_chain_in, .carry_out,
    .shift_left_out, .shift_right_out, .cond_zero_out, .cond_one_out, .crc_fb_out, .crc_msb_out);
  dp_neighbour_model i_nbr (.pclk, .presetn, .run, .route_carry_in, .route_shift_in,
    .carry_chain_in, .shift_left_chain_in, .shift_right_chain_in, .cond_zero_chain_in,
    .cond_one_chain_in, .crc_fb_chain_in, .crc_msb_chain_in);

  // one APB transfer; waits for pready, then releases and idles an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one cycle in a given state, then back to state zero
  task automatic step(input logic [2:0] s);
    state_in <= s;
    @(posedge pclk);
    state_in <= 3'h0;
    @(posedge pclk);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, fifo_zero_load, fifo_one_load, run} = 7'h00;
    {paddr, pwdata, state_in} = 43'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      `CHK("write_error", rows[i].e, er)
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("read_error", rows[i].e, er)
      if (!rows[i].e) `CHK("read_back", rows[i].r, rd)
    end
    // d0, mask 0x0F enabled, default shift value one, fifo0 from acc0, chaining on
    apb(1'b1, 8'h38, 32'h0000_003C);
    apb(1'b1, 8'h20, 32'h0000_000F);
    apb(1'b1, 8'h28, 32'h0000_0030);
    apb(1'b1, 8'h2C, 32'h0000_1003);
    for (int i = 0; i < 4; i++)
      apb(1'b1, {i[5:0] + 6'h01, 2'b00}, {16'h0000, words[i]});
    step(3'h1);
    step(3'h2);
    step(3'h3);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("masked_shift", 32'h0000_0009, rd)
    state_in <= 3'h7;
    @(negedge pclk);
    `CHK("carry", 3'h5, {carry_out, shift_left_out, shift_right_out})
    `CHK("crc", 2'h1, {crc_msb_out, crc_fb_out})
    @(posedge pclk);
    state_in <= 3'h0;
    // fifo0 loads acc0, bus reads and pops it
    fifo_zero_load <= 1'b1;
    @(posedge pclk);
    fifo_zero_load <= 1'b0;
    apb(1'b0, 8'h30, 32'h0);
    `CHK("fifo0_load", 32'h0000_0109, rd)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("fifo0_popped", 1'b0, rd[8])
    // fifo1 in bus mode: cpu writes, state 4 moves it into acc1
    apb(1'b1, 8'h34, 32'h0000_005A);
    step(3'h4);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("fifo1_to_acc", 32'h0000_5A09, rd)
    apb(1'b0, 8'h34, 32'h0);
    `CHK("fifo1_drained", 1'b0, rd[8])
    // sweep neighbour conditions with both chains on
    apb(1'b1, 8'h38, 32'h0000_0009); // d0 = acc0
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    run <= 1'b0;
    // second reset after the sweep clears words 3 to 7, statics, data and status
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 12; a <= 64; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0);
      `CHK("reset_value", 32'h0000_0000, rd)
    end
    wrap_up();
  end
endmodule
